/* hw/opdec_pkg.sv */
// Constants and types shared by the 16-bit minicomputer operation decoder.
// Assumes words are written as six octal digits, the first being bit 15 alone.
package opdec_pkg;
  localparam int W = 16;

  // Field positions
  localparam int OP4_HI   = 15;
  localparam int OP4_LO   = 12;
  localparam int GRP_HI   = 11;
  localparam int GRP_LO   = 9;
  localparam int LOP_HI   = 8;
  localparam int LOP_LO   = 3;
  localparam int MODE_HI  = 2;
  localparam int MODE_LO  = 0;
  localparam int SMODE_HI = 11;
  localparam int SMODE_LO = 9;
  localparam int F9_HI    = 8;
  localparam int F9_LO    = 0;
  localparam int SBASE_HI = 8;
  localparam int SBASE_LO = 5;
  localparam int SCNT_HI  = 4;
  localparam int SCNT_LO  = 0;
  localparam int RS_HI    = 8;
  localparam int RS_LO    = 6;
  localparam int RO_HI    = 5;
  localparam int RO_LO    = 3;
  localparam int RD_HI    = 2;
  localparam int RD_LO    = 0;
  localparam int RCOND    = 2;
  localparam int IOR_HI   = 8;
  localparam int IOR_LO   = 6;
  localparam int DEV_HI   = 5;
  localparam int DEV_LO   = 0;

  // Leading two-digit codes (bits 15..12)
  localparam logic [3:0] OP_LONG  = 4'h0;
  localparam logic [3:0] OP_IO    = 4'h8;
  localparam logic [3:0] OP_LDA_S = 4'h9;
  localparam logic [3:0] OP_XOR_S = 4'hc;
  localparam logic [3:0] OP_AND_S = 4'hd;
  localparam logic [3:0] OP_OR_S  = 4'he;
  localparam logic [3:0] OP_JMP_S = 4'hf;

  // Groups under leading 00
  localparam logic [2:0] G_LONG  = 3'h0;
  localparam logic [2:0] G_SHIFT = 3'h1;
  localparam logic [2:0] G_COPY  = 3'h2;
  localparam logic [2:0] G_DXS   = 3'h3;
  localparam logic [2:0] G_SKT   = 3'h4;
  localparam logic [2:0] G_SKF   = 3'h5;
  localparam logic [2:0] G_IXS   = 3'h6;

  // Long-form operation codes (octal 10, 20, 21, 22, 40, 41)
  localparam logic [5:0] L_DRS  = 6'h08;
  localparam logic [5:0] L_CAS  = 6'h10;
  localparam logic [5:0] L_CBS  = 6'h11;
  localparam logic [5:0] L_CXS  = 6'h12;
  localparam logic [5:0] L_LEA  = 6'h20;
  localparam logic [5:0] L_TRAP = 6'h21;

  // I/O groups
  localparam logic [2:0] IO_EXC   = 3'h0;
  localparam logic [2:0] IO_SENSE = 3'h1;
  localparam logic [2:0] IO_OUT   = 3'h2;
  localparam logic [2:0] IO_CIN   = 3'h3;
  localparam logic [2:0] IO_INTR  = 3'h4;
  localparam logic [2:0] IO_ORIN  = 3'h5;
  localparam logic [1:0] INTR_ARM_BIT = 2'h1;

  // Register selectors used by copy, I/O and compare
  localparam logic [2:0] R_NONE = 3'h0;
  localparam logic [2:0] R_A    = 3'h1;
  localparam logic [2:0] R_B    = 3'h2;
  localparam logic [2:0] R_X    = 3'h3;
  localparam logic [2:0] R_MEM  = 3'h4;

  // Skip condition mask bits
  localparam int C_SW_LO  = 0;
  localparam int C_SW_HI  = 3;
  localparam int C_OVF    = 4;
  localparam int C_APOS   = 5;
  localparam int C_AZERO  = 6;
  localparam int C_BZERO  = 7;
  localparam int C_XZERO  = 8;

  typedef enum logic [3:0] {
    CLS_NONE, CLS_LONG_MEM, CLS_SHORT_MEM, CLS_SHIFT, CLS_COPY,
    CLS_SKIP, CLS_INDEX, CLS_IO, CLS_INTR, CLS_TRAP
  } class_t;

  typedef enum logic [3:0] {
    MOP_NONE, MOP_LOAD_A, MOP_XOR_A, MOP_AND_A, MOP_OR_A, MOP_JUMP,
    MOP_DEC_SKIP, MOP_CMP_SKIP, MOP_LEA, MOP_OTHER
  } mem_op_t;

  typedef enum logic [2:0] {
    SH_ARITH_L, SH_ARITH_R, SH_LOGIC_L, SH_LOGIC_R, SH_ROTATE_L, SH_SET_OVF
  } shift_kind_t;

  typedef enum logic [1:0] {
    SR_A, SR_B, SR_PAIR
  } shift_reg_t;

  typedef enum logic [2:0] {
    CP_INC, CP_DEC, CP_PLAIN, CP_NEG, CP_COMPL, CP_A_TO_B, CP_A_TO_X, CP_X_TO_B
  } copy_op_t;
endpackage

/* hw/skip_condition_eval.sv */
// Evaluates a nine-bit skip condition mask against machine state.
// Assumes all inputs are already in the core clock domain.
`timescale 1ns/1ns
module skip_condition_eval
  import opdec_pkg::*;
(
  input  wire logic [8:0]   mask_in,
  input  wire logic [3:0]   sense_sw_in,
  input  wire logic         ovf_in,
  input  wire logic [W-1:0] a_in,
  input  wire logic [W-1:0] b_in,
  input  wire logic [W-1:0] x_in,
  output logic              cond_true_out
);
  logic a_zero;
  logic a_neg;
  logic [1:0] a_sel;
  logic a_term;

  assign a_zero = (a_in == '0);
  assign a_neg  = a_in[W-1];
  assign a_sel  = {mask_in[C_AZERO], mask_in[C_APOS]};

  // Both A bits together mean negative, not positive-or-zero
  always_comb
  begin
    case (a_sel)
      2'h1:    a_term = !a_zero && !a_neg;
      2'h2:    a_term = a_zero;
      2'h3:    a_term = a_neg;
      default: a_term = 1'b0;
    endcase
  end

  assign cond_true_out = |(mask_in[C_SW_HI:C_SW_LO] & sense_sw_in)
                       | (mask_in[C_OVF] & ovf_in)
                       | a_term
                       | (mask_in[C_BZERO] & (b_in == '0))
                       | (mask_in[C_XZERO] & (x_in == '0));
endmodule

/* hw/reg_copy_unit.sv */
// Register-copy datapath: selects source, applies the op, names destinations.
// Assumes register values are stable during the decode cycle.
`timescale 1ns/1ns
module reg_copy_unit
  import opdec_pkg::*;
(
  input  wire logic [2:0]   src_in,
  input  wire logic [2:0]   op_in,
  input  wire logic [1:0]   dst_in,
  input  wire logic [W-1:0] a_in,
  input  wire logic [W-1:0] b_in,
  input  wire logic [W-1:0] x_in,
  output logic [W-1:0]      result_out,
  output logic [2:0]        dst_out,
  output logic              side_en_out,
  output logic [2:0]        side_dst_out,
  output logic [W-1:0]      side_val_out
);
  logic [W-1:0] src;

  always_comb
  begin
    case (src_in)
      R_A:     src = a_in;
      R_B:     src = b_in;
      R_X:     src = x_in;
      default: src = '0;
    endcase
  end

  always_comb
  begin
    result_out   = src;
    side_en_out  = 1'b0;
    side_dst_out = R_NONE;
    side_val_out = '0;
    case (copy_op_t'(op_in))
      CP_INC:    result_out = src + 16'h0001;
      CP_DEC:    result_out = src - 16'h0001;
      CP_NEG:    result_out = '0 - src;
      CP_COMPL:  result_out = ~src;
      CP_A_TO_B:
      begin
        side_en_out  = 1'b1;
        side_dst_out = R_B;
        side_val_out = a_in;
      end
      CP_A_TO_X:
      begin
        side_en_out  = 1'b1;
        side_dst_out = R_X;
        side_val_out = a_in;
      end
      CP_X_TO_B:
      begin
        side_en_out  = 1'b1;
        side_dst_out = R_B;
        side_val_out = x_in;
      end
      default:   result_out = src;
    endcase
  end

  assign dst_out = {1'b0, dst_in};
endmodule

/* hw/opcode_decoder.sv */
// Operation decoder for the 16-bit minicomputer: classifies a fetched word
// and drives registered execution controls for one cycle per accepted word.
// Assumes instr_in, operand_in and register values come from core-clock logic;
// only the sense switches arrive from pins.
//
// What this block does
// - Leading 01-07 and 11-17 is short memory reference; 17 jumps, 11 loads A.
// - Short 14, 15, 16 XOR, AND, OR memory into A.
// - Long 10 decrements memory, writes back, skips when result is zero.
// - Long 20, 21, 22 compare memory with A, B or X and skip.
// - Load effective address into X is long 40; 41 through 77 trap.
// - Group 001 bases 000-500 are arithmetic shifts of A, B, pair.
// - Bases 040-540 are logical shifts; 600, 640, 700 rotate left.
// - Group 003 decrements X, group 006 increments X, skipping on zero.
// - Group 004 skips on true, 005 on false; 005 mask 0 always skips.
// - Mask bits: switches 1-4, overflow, A positive/zero/negative, B zero, X zero.
// - Register copy 002 s op d with eight operations on source and destination.
// - Conditional copy variants write only while overflow is set.
// - I/O group 0 is external control: r 0 immediate, 1-3 registers, else memory.
// - Group 3 clears then inputs; group 5 ORs input into A, B, X.
// - I/O group 1 senses device status into A, B, X or memory.
// - Group 1 with r 0 senses masked status and skips when zero.
// - 10 4 000/001 disarm, 002/003 arm; even clears overflow, odd sets.
// - Code 10 4 003 arms interrupts and sets overflow together.
// - Short 16 ORs the addressed memory word into A.
`timescale 1ns/1ns
module opcode_decoder
  import opdec_pkg::*;
(
  input  wire logic          core_clk_in,
  input  wire logic          rst_in,
  input  wire logic          instr_valid_in,
  input  wire logic [W-1:0]  instr_in,
  input  wire logic [W-1:0]  operand_in,
  input  wire logic [W-1:0]  dev_status_in,
  input  wire logic [W-1:0]  a_in,
  input  wire logic [W-1:0]  b_in,
  input  wire logic [W-1:0]  x_in,
  input  wire logic          ovf_in,
  input  wire logic [3:0]    sense_sw_in,
  output logic               done_out,
  output class_t             class_out,
  output mem_op_t            mem_op_out,
  output logic [2:0]         mode_out,
  output logic [8:0]         addr_out,
  output logic [2:0]         cmp_reg_out,
  output logic [W-1:0]       result_out,
  output logic               mem_write_out,
  output logic               skip_out,
  output shift_kind_t        shift_kind_out,
  output shift_reg_t         shift_reg_out,
  output logic [4:0]         shift_count_out,
  output logic               reg_write_out,
  output logic [2:0]         reg_dst_out,
  output logic               side_write_out,
  output logic [2:0]         side_dst_out,
  output logic [W-1:0]       side_val_out,
  output logic [2:0]         io_group_out,
  output logic [2:0]         io_reg_out,
  output logic [5:0]         io_dev_out,
  output logic               io_clear_first_out,
  output logic               io_or_in_out,
  output logic               intr_armed_out,
  output logic               ovf_set_out,
  output logic               ovf_clear_out
);
  // Switch pins are asynchronous; first stage feeds only the second
  logic [3:0] sw_meta;
  logic [3:0] sw_sync;

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sw_meta <= '0;
      sw_sync <= '0;
    end
    else
    begin
      sw_meta <= sense_sw_in;
      sw_sync <= sw_meta;
    end
  end

  // Field extraction
  logic [3:0] op4;
  logic [2:0] grp;
  logic [5:0] lop;
  logic [8:0] f9;
  logic [2:0] io_r;

  assign op4  = instr_in[OP4_HI:OP4_LO];
  assign grp  = instr_in[GRP_HI:GRP_LO];
  assign lop  = instr_in[LOP_HI:LOP_LO];
  assign f9   = instr_in[F9_HI:F9_LO];
  assign io_r = instr_in[IOR_HI:IOR_LO];

  logic cond_true;

  skip_condition_eval u_cond (
    .mask_in       (f9),
    .sense_sw_in   (sw_sync),
    .ovf_in        (ovf_in),
    .a_in          (a_in),
    .b_in          (b_in),
    .x_in          (x_in),
    .cond_true_out (cond_true)
  );

  logic [W-1:0] cp_result;
  logic [2:0]   cp_dst;
  logic         cp_side_en;
  logic [2:0]   cp_side_dst;
  logic [W-1:0] cp_side_val;

  reg_copy_unit u_copy (
    .src_in       (instr_in[RS_HI:RS_LO]),
    .op_in        (instr_in[RO_HI:RO_LO]),
    .dst_in       (instr_in[RD_HI-1:RD_LO]),
    .a_in         (a_in),
    .b_in         (b_in),
    .x_in         (x_in),
    .result_out   (cp_result),
    .dst_out      (cp_dst),
    .side_en_out  (cp_side_en),
    .side_dst_out (cp_side_dst),
    .side_val_out (cp_side_val)
  );

  logic         next_done;
  class_t       next_cls;
  mem_op_t      next_mop;
  logic [2:0]   next_mode;
  logic [8:0]   next_addr;
  logic [2:0]   next_cmp_reg;
  logic [W-1:0] next_result;
  logic         next_mem_write;
  logic         next_skip;
  shift_kind_t  next_sh_kind;
  shift_reg_t   next_sh_reg;
  logic [4:0]   next_sh_cnt;
  logic         next_reg_write;
  logic [2:0]   next_reg_dst;
  logic         next_side_write;
  logic [2:0]   next_side_dst;
  logic [W-1:0] next_side_val;
  logic [2:0]   next_io_group;
  logic [2:0]   next_io_reg;
  logic [5:0]   next_io_dev;
  logic         next_io_clear;
  logic         next_io_or;
  logic         next_armed;
  logic         next_ovf_set;
  logic         next_ovf_clear;

  always_comb
  begin
    next_done       = instr_valid_in;
    next_cls        = CLS_NONE;
    next_mop        = MOP_NONE;
    next_mode       = '0;
    next_addr       = '0;
    next_cmp_reg    = R_NONE;
    next_result     = '0;
    next_mem_write  = 1'b0;
    next_skip       = 1'b0;
    next_sh_kind    = SH_ARITH_L;
    next_sh_reg     = SR_A;
    next_sh_cnt     = '0;
    next_reg_write  = 1'b0;
    next_reg_dst    = R_NONE;
    next_side_write = 1'b0;
    next_side_dst   = R_NONE;
    next_side_val   = '0;
    next_io_group   = '0;
    next_io_reg     = R_NONE;
    next_io_dev     = '0;
    next_io_clear   = 1'b0;
    next_io_or      = 1'b0;
    next_armed      = intr_armed_out;
    next_ovf_set    = 1'b0;
    next_ovf_clear  = 1'b0;
    if (instr_valid_in)
    begin
      if (op4 == OP_IO)
      begin
        next_cls      = CLS_IO;
        next_io_group = grp;
        next_io_dev   = instr_in[DEV_HI:DEV_LO];
        // Register sources 1-3 map directly; 0 immediate; the rest memory
        next_io_reg   = (io_r > R_X) ? R_MEM : io_r;
        case (grp)
          IO_CIN:   next_io_clear = 1'b1;
          IO_ORIN:  next_io_or    = 1'b1;
          IO_SENSE:
            if (io_r == R_NONE)
              next_skip = ((dev_status_in & operand_in) == '0);
          IO_INTR:
          begin
            next_cls       = CLS_INTR;
            next_io_reg    = R_NONE;
            next_armed     = instr_in[INTR_ARM_BIT];
            next_ovf_set   = instr_in[0];
            next_ovf_clear = !instr_in[0];
          end
          default:  next_io_clear = 1'b0;
        endcase
      end
      else if (op4 != OP_LONG)
      begin
        next_cls  = CLS_SHORT_MEM;
        next_mode = instr_in[SMODE_HI:SMODE_LO];
        next_addr = f9;
        case (op4)
          OP_JMP_S: next_mop = MOP_JUMP;
          OP_LDA_S: next_mop = MOP_LOAD_A;
          OP_XOR_S: next_mop = MOP_XOR_A;
          OP_AND_S: next_mop = MOP_AND_A;
          OP_OR_S:  next_mop = MOP_OR_A;
          default:  next_mop = MOP_OTHER;
        endcase
        if (next_mop inside {MOP_LOAD_A, MOP_XOR_A, MOP_AND_A, MOP_OR_A})
        begin
          next_reg_write = 1'b1;
          next_reg_dst   = R_A;
          case (next_mop)
            MOP_XOR_A: next_result = a_in ^ operand_in;
            MOP_AND_A: next_result = a_in & operand_in;
            MOP_OR_A:  next_result = a_in | operand_in;
            default:   next_result = operand_in;
          endcase
        end
      end
      else
      begin
        case (grp)
          G_LONG:
          begin
            next_cls  = CLS_LONG_MEM;
            next_mode = instr_in[MODE_HI:MODE_LO];
            next_mop  = MOP_OTHER;
            if (lop == L_DRS)
            begin
              next_mop       = MOP_DEC_SKIP;
              next_result    = operand_in - 16'h0001;
              next_mem_write = 1'b1;
              next_skip      = (operand_in == 16'h0001);
            end
            else if (lop >= L_CAS && lop <= L_CXS)
            begin
              next_mop     = MOP_CMP_SKIP;
              next_cmp_reg = (lop == L_CAS) ? R_A : (lop == L_CBS) ? R_B : R_X;
            end
            else if (lop == L_LEA)
            begin
              next_mop       = MOP_LEA;
              next_reg_write = 1'b1;
              next_reg_dst   = R_X;
              next_result    = operand_in;
            end
            else if (lop >= L_TRAP)
            begin
              next_cls = CLS_TRAP;
              next_mop = MOP_NONE;
            end
          end
          G_SHIFT:
          begin
            next_cls    = CLS_SHIFT;
            next_sh_cnt = instr_in[SCNT_HI:SCNT_LO];
            case (instr_in[SBASE_HI:SBASE_LO])
              4'h0, 4'h4, 4'h8:  next_sh_kind = SH_ARITH_L;
              4'h1, 4'h5, 4'h9:  next_sh_kind = SH_LOGIC_L;
              4'h2, 4'h6, 4'ha:  next_sh_kind = SH_ARITH_R;
              4'h3, 4'h7, 4'hb:  next_sh_kind = SH_LOGIC_R;
              4'hc, 4'hd, 4'he:  next_sh_kind = SH_ROTATE_L;
              default:           next_sh_kind = SH_SET_OVF;
            endcase
            case (instr_in[SBASE_HI:SBASE_LO])
              4'h4, 4'h5, 4'h6, 4'h7, 4'hd: next_sh_reg = SR_B;
              4'h8, 4'h9, 4'ha, 4'hb, 4'he: next_sh_reg = SR_PAIR;
              default:                      next_sh_reg = SR_A;
            endcase
            next_ovf_set = (next_sh_kind == SH_SET_OVF);
          end
          G_COPY:
          begin
            next_cls      = CLS_COPY;
            next_result   = cp_result;
            next_reg_dst  = cp_dst;
            next_side_dst = cp_side_dst;
            next_side_val = cp_side_val;
            // A conditional copy without overflow leaves destinations alone
            if (!instr_in[RCOND] || ovf_in)
            begin
              next_reg_write  = (cp_dst != R_NONE);
              next_side_write = cp_side_en;
            end
          end
          G_DXS:
          begin
            next_cls       = CLS_INDEX;
            next_reg_write = 1'b1;
            next_reg_dst   = R_X;
            next_result    = x_in - 16'h0001;
            next_skip      = (x_in == 16'h0001);
          end
          G_IXS:
          begin
            next_cls       = CLS_INDEX;
            next_reg_write = 1'b1;
            next_reg_dst   = R_X;
            next_result    = x_in + 16'h0001;
            next_skip      = (x_in == 16'hffff);
          end
          G_SKT:
          begin
            next_cls  = CLS_SKIP;
            next_skip = cond_true;
          end
          G_SKF:
          begin
            next_cls  = CLS_SKIP;
            next_skip = !cond_true;
          end
          default: next_cls = CLS_NONE;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      done_out <= 1'b0;
      class_out <= CLS_NONE;
      mem_op_out <= MOP_NONE;
      mode_out <= '0;
      addr_out <= '0;
      cmp_reg_out <= R_NONE;
      result_out <= '0;
      mem_write_out <= 1'b0;
      skip_out <= 1'b0;
      shift_kind_out <= SH_ARITH_L;
      shift_reg_out <= SR_A;
      shift_count_out <= '0;
      reg_write_out <= 1'b0;
      reg_dst_out <= R_NONE;
      side_write_out <= 1'b0;
      side_dst_out <= R_NONE;
      side_val_out <= '0;
      io_group_out <= '0;
      io_reg_out <= R_NONE;
      io_dev_out <= '0;
      io_clear_first_out <= 1'b0;
      io_or_in_out <= 1'b0;
      intr_armed_out <= 1'b0;
      ovf_set_out <= 1'b0;
      ovf_clear_out <= 1'b0;
    end
    else
    begin
      done_out <= next_done;
      class_out <= next_cls;
      mem_op_out <= next_mop;
      mode_out <= next_mode;
      addr_out <= next_addr;
      cmp_reg_out <= next_cmp_reg;
      result_out <= next_result;
      mem_write_out <= next_mem_write;
      skip_out <= next_skip;
      shift_kind_out <= next_sh_kind;
      shift_reg_out <= next_sh_reg;
      shift_count_out <= next_sh_cnt;
      reg_write_out <= next_reg_write;
      reg_dst_out <= next_reg_dst;
      side_write_out <= next_side_write;
      side_dst_out <= next_side_dst;
      side_val_out <= next_side_val;
      io_group_out <= next_io_group;
      io_reg_out <= next_io_reg;
      io_dev_out <= next_io_dev;
      io_clear_first_out <= next_io_clear;
      io_or_in_out <= next_io_or;
      intr_armed_out <= next_armed;
      ovf_set_out <= next_ovf_set;
      ovf_clear_out <= next_ovf_clear;
    end
  end
endmodule

/* testbench/opdec_props.sv */
// Concurrent checks on the decoder's ports.
// Assumes one clock domain and latency one from an accepted word.
`timescale 1ns/1ns
module opdec_props
  import opdec_pkg::*;
(
  input wire logic         core_clk_in,
  input wire logic         rst_in,
  input wire logic         instr_valid_in,
  input wire logic [W-1:0] instr_in,
  input wire logic [W-1:0] operand_in,
  input wire logic [W-1:0] a_in,
  input wire logic         done_out,
  input wire class_t       class_out,
  input wire mem_op_t      mem_op_out,
  input wire logic [W-1:0] result_out,
  input wire logic         mem_write_out,
  input wire logic         skip_out,
  input wire logic         intr_armed_out,
  input wire logic         ovf_set_out,
  input wire logic         ovf_clear_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_take(logic [3:0] op);
    instr_valid_in && instr_in[15:12] == op;
  endsequence
  sequence s_long(logic [5:0] lop);
    instr_valid_in && instr_in[15:9] == 7'h00 && instr_in[8:3] == lop;
  endsequence
  property p_done;
    done_out == $past(instr_valid_in);
  endproperty
  property p_load;
    s_take(OP_LDA_S) |=> mem_op_out == MOP_LOAD_A && result_out == $past(operand_in);
  endproperty
  property p_jump;
    s_take(OP_JMP_S) |=> class_out == CLS_SHORT_MEM && mem_op_out == MOP_JUMP;
  endproperty
  property p_xor;
    s_take(OP_XOR_S) |=> result_out == ($past(a_in) ^ $past(operand_in));
  endproperty
  property p_or;
    s_take(OP_OR_S) |=> result_out == ($past(a_in) | $past(operand_in));
  endproperty
  property p_drs;
    s_long(L_DRS) |=> mem_write_out && skip_out == ($past(operand_in) == 16'h0001);
  endproperty
  property p_trap;
    s_long(L_TRAP) |=> class_out == CLS_TRAP;
  endproperty
  property p_skf0;
    instr_valid_in && instr_in == 16'h0a00 |=> skip_out;
  endproperty
  property p_arm;
    instr_valid_in && instr_in == 16'h8803 |=> intr_armed_out && ovf_set_out && !ovf_clear_out;
  endproperty
  property p_disarm;
    instr_valid_in && instr_in == 16'h8800 |=> !intr_armed_out && ovf_clear_out;
  endproperty
  a_done: assert property (p_done) else $error("done not one cycle after word");
  a_load: assert property (p_load) else $error("short load wrong");
  a_jump: assert property (p_jump) else $error("short jump wrong");
  a_xor: assert property (p_xor) else $error("short xor wrong");
  a_or: assert property (p_or) else $error("short or wrong");
  a_drs: assert property (p_drs) else $error("decrement skip wrong");
  a_trap: assert property (p_trap) else $error("code 41 not trapped");
  a_skf0: assert property (p_skf0) else $error("empty false mask no skip");
  a_arm: assert property (p_arm) else $error("arm with overflow wrong");
  a_disarm: assert property (p_disarm) else $error("disarm wrong");
endmodule
bind opcode_decoder opdec_props u_props (.core_clk_in, .rst_in, .instr_valid_in, .instr_in,
  .operand_in, .a_in, .done_out, .class_out, .mem_op_out, .result_out, .mem_write_out,
  .skip_out, .intr_armed_out, .ovf_set_out, .ovf_clear_out);

/* testbench/fetch_model.sv */
// Fetch path feeding words to the decoder.
// Between words the lines are scrambled so stale values never look valid.
`timescale 1ns/1ns
module fetch_model
(
  input  wire logic        core_clk_in,
  input  wire logic        req_in,
  input  wire logic [15:0] word_in,
  input  wire logic [15:0] opnd_in,
  output logic             valid_out,
  output logic [15:0]      instr_out,
  output logic [15:0]      operand_out
);
  logic [15:0] last;
  always_ff @(posedge core_clk_in) last <= ~instr_out;
  assign valid_out   = req_in;
  assign instr_out   = req_in ? word_in : last;
  assign operand_out = req_in ? opnd_in : ~last;
endmodule

/* testbench/minicomputer_opcode_decoder_tb.sv */
// Directed bench for the operation decoder.
// Assumes answers one cycle after each accepted word.
`timescale 1ns/1ns
module minicomputer_opcode_decoder_tb;
  import opdec_pkg::*;
  logic clk = 0, rst = 1, req = 0, ov = 0, v, dn, mw, sk, rw, sw, cf, oi, ia, os, oc;
  logic [15:0] w = 0, o = 0, a = 0, x = 0, ins, opd, res, sv;
  logic [3:0] ssw = 0;
  logic [2:0] md, cr, rd, sd, ig, ir;
  logic [8:0] ad;
  logic [5:0] dv;
  logic [4:0] sc;
  class_t cl;
  mem_op_t mo;
  shift_kind_t sk_k;
  shift_reg_t sk_r;
  int mismatches = 0, total_checks = 0;
  initial forever #20 clk = ~clk;
  fetch_model fm (.core_clk_in(clk), .req_in(req), .word_in(w), .opnd_in(o),
    .valid_out(v), .instr_out(ins), .operand_out(opd));
  opcode_decoder uut (.core_clk_in(clk), .rst_in(rst), .instr_valid_in(v), .instr_in(ins),
    .operand_in(opd), .dev_status_in(16'h00f0), .a_in(a), .b_in(16'h1234), .x_in(x),
    .ovf_in(ov), .sense_sw_in(ssw), .done_out(dn), .class_out(cl), .mem_op_out(mo),
    .mode_out(md), .addr_out(ad), .cmp_reg_out(cr), .result_out(res), .mem_write_out(mw),
    .skip_out(sk), .shift_kind_out(sk_k), .shift_reg_out(sk_r), .shift_count_out(sc),
    .reg_write_out(rw), .reg_dst_out(rd), .side_write_out(sw), .side_dst_out(sd),
    .side_val_out(sv), .io_group_out(ig), .io_reg_out(ir), .io_dev_out(dv),
    .io_clear_first_out(cf), .io_or_in_out(oi), .intr_armed_out(ia), .ovf_set_out(os),
    .ovf_clear_out(oc));
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // One word for one cycle; answer read just after the taking edge
  task automatic send(logic [15:0] wv, ov_, av, xv, logic f);
    @(posedge clk);
    req <= 1; w <= wv; o <= ov_; a <= av; x <= xv; ov <= f;
    @(posedge clk);
    req <= 0;
    #1 chk("done", 1, dn);
  endtask
  task automatic t_short;
    send(16'h9205, 16'h4321, 0, 0, 0); chk("res", 16'h4321, res); chk("mode", 1, md);
    chk("addr", 5, ad); chk("dst", R_A, rd);
    send(16'hf000, 0, 0, 0, 0); chk("mop", MOP_JUMP, mo);
    send(16'hc000, 16'h0f0f, 16'h00ff, 0, 0); chk("xor", 16'h0ff0, res);
    send(16'hd000, 16'h0f0f, 16'h00ff, 0, 0); chk("and", 16'h000f, res);
    send(16'he000, 16'h0f0f, 16'h00ff, 0, 0); chk("or", 16'h0fff, res);
  endtask
  task automatic t_long;
    send(16'h0041, 1, 0, 0, 0); chk("skip", 1, sk); chk("res", 0, res); chk("mw", 1, mw);
    send(16'h0041, 5, 0, 0, 0); chk("skip", 0, sk); chk("res", 4, res);
    send(16'h0091, 0, 0, 0, 0); chk("cmp", R_X, cr);
    send(16'h0102, 0, 0, 0, 0); chk("mop", MOP_LEA, mo);
    send(16'h0108, 0, 0, 0, 0); chk("cls", CLS_TRAP, cl);
  endtask
  task automatic t_shift;
    send(16'h0303, 0, 0, 0, 0); chk("kind", SH_ARITH_L, sk_k); chk("cnt", 3, sc);
    chk("reg", SR_PAIR, sk_r);
    send(16'h0360, 0, 0, 0, 0); chk("kind", SH_LOGIC_R, sk_k); chk("reg", SR_PAIR, sk_r);
    send(16'h03c5, 0, 0, 0, 0); chk("kind", SH_ROTATE_L, sk_k); chk("cnt", 5, sc);
  endtask
  task automatic t_skip;
    send(16'h0603, 0, 0, 1, 0); chk("skip", 1, sk); chk("res", 0, res);
    send(16'h0c03, 0, 0, 16'hffff, 0); chk("skip", 1, sk);
    send(16'h0840, 0, 0, 0, 0); chk("skip", 1, sk);
    send(16'h0840, 0, 5, 0, 0); chk("skip", 0, sk);
    send(16'h0860, 0, 16'h8000, 0, 0); chk("skip", 1, sk);
    send(16'h0810, 0, 0, 0, 1); chk("skip", 1, sk);
    send(16'h0900, 0, 0, 0, 0); chk("skip", 1, sk);
    send(16'h0a08, 0, 0, 0, 0); chk("skip", 0, sk);
    send(16'h0a00, 0, 1, 1, 0); chk("skip", 1, sk);
  endtask
  task automatic t_copy;
    send(16'h0452, 0, 16'h0055, 0, 0); chk("res", 16'h0055, res); chk("dst", R_B, rd);
    send(16'h045a, 0, 16'h0055, 0, 0); chk("neg", 16'hffab, res);
    send(16'h047a, 0, 16'h0055, 16'h0011, 0); chk("side", R_B, sd); chk("sv", 16'h11, sv);
    send(16'h047e, 0, 16'h0055, 0, 0); chk("wr", 0, rw); chk("sw", 0, sw);
    send(16'h047e, 0, 16'h0055, 0, 1); chk("wr", 1, rw); chk("sw", 1, sw);
  endtask
  task automatic t_io;
    send(16'h8003, 0, 0, 0, 0); chk("grp", IO_EXC, ig); chk("reg", 0, ir);
    send(16'h8445, 0, 0, 0, 0); chk("reg", R_A, ir); chk("dev", 5, dv);
    send(16'h8707, 0, 0, 0, 0); chk("clr", 1, cf); chk("reg", R_MEM, ir);
    send(16'h8a41, 0, 0, 0, 0); chk("or", 1, oi);
    send(16'h8242, 0, 0, 0, 0); chk("grp", IO_SENSE, ig); chk("reg", R_A, ir);
    send(16'h8202, 16'h000f, 0, 0, 0); chk("skip", 1, sk);
    send(16'h8202, 16'h0010, 0, 0, 0); chk("skip", 0, sk);
    send(16'h8803, 0, 0, 0, 0); chk("arm", 1, ia); chk("set", 1, os);
    send(16'h8800, 0, 0, 0, 0); chk("arm", 0, ia); chk("clr", 1, oc);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (2000) @(posedge clk);
    mismatches++;
    wrap_up;
  end
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 0;
    ssw <= 4'h8;
    repeat (3) @(posedge clk);
    t_short;
    t_long;
    t_shift;
    t_skip;
    t_copy;
    t_io;
    wrap_up;
  end
endmodule
